// *** scfp_pkg.sv ***
// constants, types and register map of the feature and power command block
package scfp_pkg;
    // register indices; byte address is four times the index
    localparam int unsigned IDX_FEAT = 1;
    localparam int unsigned IDX_CNT = 2;
    localparam int unsigned IDX_SEC = 3;
    localparam int unsigned IDX_CYLLO = 4;
    localparam int unsigned IDX_CYLHI = 5;
    localparam int unsigned IDX_DRVHD = 6;
    localparam int unsigned IDX_CMD = 7;
    localparam int unsigned IDX_MODE = 8;
    localparam int unsigned IDX_PWR = 9;
    localparam int unsigned IDX_CTRL = 10;
    localparam int unsigned ADDR_W = 6;
    // command codes
    localparam logic [7:0] CMD_SETF = 8'hEF;
    localparam logic [7:0] CMD_SMUL = 8'hC6;
    localparam logic [7:0] CMD_SLP0 = 8'h99;
    localparam logic [7:0] CMD_SLP1 = 8'hE6;
    localparam logic [7:0] CMD_STB0 = 8'h96;
    localparam logic [7:0] CMD_STB1 = 8'hE2;
    // subcommand codes
    localparam logic [7:0] F_WCE = 8'h02;
    localparam logic [7:0] F_WCD = 8'h82;
    localparam logic [7:0] F_XFER = 8'h03;
    localparam logic [7:0] F_APME = 8'h05;
    localparam logic [7:0] F_APMD = 8'h85;
    localparam logic [7:0] F_PL1E = 8'h0A;
    localparam logic [7:0] F_PL1D = 8'h8A;
    localparam logic [7:0] F_AHDOFF = 8'h55;
    localparam logic [7:0] F_AHDON = 8'hAA;
    localparam logic [7:0] F_LECC = 8'h44;
    localparam logic [7:0] F_L4 = 8'hBB;
    localparam logic [7:0] F_CUR = 8'h9A;
    localparam logic [7:0] F_PORD = 8'h66;
    localparam logic [7:0] F_PORE = 8'hCC;
    localparam logic [7:0] F_NOP0 = 8'h69;
    localparam logic [7:0] F_NOP1 = 8'h96;
    localparam logic [7:0] F_NOP2 = 8'h97;
    // transfer type field and levels
    localparam logic [4:0] XT_PIO = 5'h00;
    localparam logic [4:0] XT_FLOW = 5'h01;
    localparam logic [4:0] XT_MDMA = 5'h04;
    localparam logic [2:0] PIO_FLOW_MIN = 3'h3;
    localparam logic [7:0] APM_RSV_LO = 8'h00;
    localparam logic [7:0] APM_RSV_HI = 8'hFF;
    localparam logic [7:0] APM_NOSTBY = 8'h80;
    // status and error bit positions, control bit
    localparam int unsigned ST_BUSY = 7;
    localparam int unsigned ST_RDY = 6;
    localparam int unsigned ST_SLP = 1;
    localparam int unsigned ST_ERR = 0;
    localparam int unsigned ER_ABRT = 2;
    localparam int unsigned CT_SRST = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned IDLE_MS = 5;
    localparam int unsigned IDLE_CYC = IDLE_MS * CLK_KHZ;

    typedef struct packed {
        logic wcache;
        logic [2:0] pio;
        logic [2:0] dma;
        logic flowOff;
        logic apmEn;
        logic [7:0] apmLvl;
        logic pl1;
        logic ahead;
        logic longEcc;
        logic [7:0] curLim;
        logic porKeep;
        logic multEn;
        logic [7:0] multCnt;
    } scfp_cfg_t;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH, ST_DONE} scfp_state_t;
endpackage

// *** scfp_feature_power.sv ***
// task-file command block: set features, set multiple, sleep and standby
`timescale 1ns/1ps
`default_nettype none
module scfp_feature_power #(
    parameter logic [2:0] PIO_MAX = 3'h4,
    parameter logic [2:0] DMA_MAX = 3'h2,
    parameter bit DMA_OK = 1'b1,
    parameter bit FLOW_OFF_OK = 1'b1,
    parameter bit APM_DIS_OK = 1'b1,
    parameter bit EXT_POWER = 1'b1,
    parameter logic [7:0] CUR_MIN = 8'h05,
    parameter logic [7:0] CUR_MAX = 8'h32,
    parameter logic [7:0] MULT_MAX = 8'h10,
    parameter int unsigned IDLE_CYCLES = scfp_pkg::IDLE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic flushReq,
    input wire logic flushDone,
    output logic busy_flag,
    output logic cmdIrq,
    output logic sleepMode,
    output logic flow_ready_signal,
    output logic standbyOk,
    output logic writeCacheEn,
    output logic [2:0] pioMode,
    output logic [2:0] dmaMode
);
    localparam scfp_pkg::scfp_cfg_t CFG_DEF = '{
        wcache: 1'b0, pio: 3'h0, dma: 3'h0, flowOff: 1'b0, apmEn: 1'b0,
        apmLvl: 8'hFE, pl1: EXT_POWER, ahead: 1'b0, longEcc: 1'b0,
        curLim: CUR_MAX, porKeep: 1'b0, multEn: 1'b0, multCnt: 8'h00};
    localparam logic [19:0] IDLE_LAST = 20'(IDLE_CYCLES - 1);

    scfp_pkg::scfp_cfg_t cfg_ff;
    scfp_pkg::scfp_cfg_t nxt_cfg;
    scfp_pkg::scfp_state_t state_ff;
    logic [7:0] tf_ff [1:6];
    logic [7:0] cmd_ff;
    logic [7:0] awIdx_ff;
    logic [31:0] wdat_ff;
    logic wlane_ff;
    logic errFlag_ff;
    logic sleepPend_ff;
    logic srst_ff;
    logic [19:0] idle_ff;
    logic nxt_abort;
    logic nxt_flush;
    logic nxt_sleep;
    logic nxt_wb;
    logic wrFire;
    logic cmdTake;
    localparam int unsigned ADDR_IDX_W = scfp_pkg::ADDR_W;
    logic [ADDR_IDX_W-1:0] wIdx;
    logic [ADDR_IDX_W-1:0] rIdx;
    logic [31:0] rdVal;
    logic rdBad;
    logic wrBad;

    // bus write: address and data are taken in either order
    assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wIdx = awIdx_ff[7:2];
    assign rIdx = s_axi_araddr[7:2];
    assign wrBad = (wIdx == 6'(0)) || (wIdx > 6'(scfp_pkg::IDX_CTRL));
    assign cmdTake = wrFire && wlane_ff && (wIdx == 6'(scfp_pkg::IDX_CMD))
        && (state_ff == scfp_pkg::ST_IDLE);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= scfp_pkg::RESP_OKAY;
            awIdx_ff <= 8'h00;
            wdat_ff <= 32'h0000_0000;
            wlane_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awIdx_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdat_ff <= s_axi_wdata;
                wlane_ff <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrBad ? scfp_pkg::RESP_SLVERR : scfp_pkg::RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read mux: index 1 gives the error byte, index 7 the status byte
    always_comb begin
        rdVal = 32'h0000_0000;
        rdBad = 1'b0;
        if (rIdx == 6'(scfp_pkg::IDX_FEAT)) begin
            rdVal[scfp_pkg::ER_ABRT] = errFlag_ff;
        end else if (rIdx >= 6'(scfp_pkg::IDX_CNT) && rIdx <= 6'(scfp_pkg::IDX_DRVHD)) begin
            rdVal[7:0] = tf_ff[rIdx[2:0]];
        end else if (rIdx == 6'(scfp_pkg::IDX_CMD)) begin
            rdVal[scfp_pkg::ST_BUSY] = busy_flag;
            rdVal[scfp_pkg::ST_RDY] = !busy_flag;
            rdVal[scfp_pkg::ST_SLP] = sleepMode;
            rdVal[scfp_pkg::ST_ERR] = errFlag_ff;
        end else if (rIdx == 6'(scfp_pkg::IDX_MODE)) begin
            rdVal[15:0] = {cfg_ff.multCnt, cfg_ff.multEn, cfg_ff.flowOff,
                cfg_ff.dma, cfg_ff.pio};
        end else if (rIdx == 6'(scfp_pkg::IDX_PWR)) begin
            rdVal[23:0] = {cfg_ff.curLim, cfg_ff.apmLvl, cfg_ff.apmEn,
                cfg_ff.pl1, cfg_ff.ahead, cfg_ff.longEcc, cfg_ff.wcache,
                cfg_ff.porKeep, standbyOk, flow_ready_signal};
        end else if (rIdx != 6'(scfp_pkg::IDX_CTRL)) begin
            rdBad = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= scfp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdVal;
            s_axi_rresp <= rdBad ? scfp_pkg::RESP_SLVERR : scfp_pkg::RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // command decode, evaluated in the execute cycle
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_abort = 1'b0;
        nxt_flush = 1'b0;
        nxt_sleep = 1'b0;
        nxt_wb = 1'b0;
        case (cmd_ff)
            scfp_pkg::CMD_SETF: begin
                case (tf_ff[scfp_pkg::IDX_FEAT])
                    scfp_pkg::F_WCE: nxt_cfg.wcache = 1'b1;
                    scfp_pkg::F_WCD: begin
                        nxt_cfg.wcache = 1'b0;
                        nxt_flush = cfg_ff.wcache;
                    end
                    scfp_pkg::F_XFER: begin
                        // one field each for PIO and DMA keeps a single selection
                        case (tf_ff[scfp_pkg::IDX_CNT][7:3])
                            scfp_pkg::XT_PIO: begin
                                if (tf_ff[scfp_pkg::IDX_CNT][2:0] == 3'h0) begin
                                    nxt_cfg.pio = 3'h0;
                                    nxt_cfg.flowOff = 1'b0;
                                end else if (tf_ff[scfp_pkg::IDX_CNT][2:0] == 3'h1
                                    && FLOW_OFF_OK) begin
                                    nxt_cfg.pio = 3'h0;
                                    nxt_cfg.flowOff = 1'b1;
                                end else begin
                                    nxt_abort = 1'b1;
                                end
                            end
                            scfp_pkg::XT_FLOW: begin
                                if (tf_ff[scfp_pkg::IDX_CNT][2:0] <= PIO_MAX) begin
                                    nxt_cfg.pio = tf_ff[scfp_pkg::IDX_CNT][2:0];
                                    nxt_cfg.flowOff = 1'b0;
                                end else begin
                                    nxt_abort = 1'b1;
                                end
                            end
                            scfp_pkg::XT_MDMA: begin
                                if (DMA_OK && tf_ff[scfp_pkg::IDX_CNT][2:0] <= DMA_MAX) begin
                                    nxt_cfg.dma = tf_ff[scfp_pkg::IDX_CNT][2:0];
                                end else begin
                                    nxt_abort = 1'b1;
                                end
                            end
                            default: nxt_abort = 1'b1;
                        endcase
                    end
                    scfp_pkg::F_APME: begin
                        if (tf_ff[scfp_pkg::IDX_CNT] == scfp_pkg::APM_RSV_LO
                            || tf_ff[scfp_pkg::IDX_CNT] == scfp_pkg::APM_RSV_HI) begin
                            nxt_abort = 1'b1;
                        end else begin
                            nxt_cfg.apmEn = 1'b1;
                            nxt_cfg.apmLvl = tf_ff[scfp_pkg::IDX_CNT];
                        end
                    end
                    scfp_pkg::F_APMD: begin
                        if (APM_DIS_OK) begin
                            nxt_cfg.apmEn = 1'b0;
                        end else begin
                            nxt_abort = 1'b1;
                        end
                    end
                    scfp_pkg::F_PL1E: nxt_cfg.pl1 = 1'b1;
                    scfp_pkg::F_PL1D: nxt_cfg.pl1 = 1'b0;
                    scfp_pkg::F_AHDOFF: nxt_cfg.ahead = 1'b0;
                    scfp_pkg::F_AHDON: nxt_cfg.ahead = 1'b1;
                    scfp_pkg::F_LECC: nxt_cfg.longEcc = 1'b1;
                    scfp_pkg::F_L4: nxt_cfg.longEcc = 1'b0;
                    scfp_pkg::F_CUR: begin
                        nxt_wb = 1'b1;
                        if (tf_ff[scfp_pkg::IDX_CNT] < CUR_MIN) begin
                            nxt_cfg.curLim = CUR_MIN;
                        end else if (tf_ff[scfp_pkg::IDX_CNT] > CUR_MAX) begin
                            nxt_cfg.curLim = CUR_MAX;
                        end else begin
                            nxt_cfg.curLim = tf_ff[scfp_pkg::IDX_CNT];
                        end
                    end
                    scfp_pkg::F_PORD: nxt_cfg.porKeep = 1'b1;
                    scfp_pkg::F_PORE: nxt_cfg.porKeep = 1'b0;
                    scfp_pkg::F_NOP0, scfp_pkg::F_NOP1, scfp_pkg::F_NOP2: begin
                    end
                    default: nxt_abort = 1'b1;
                endcase
            end
            scfp_pkg::CMD_SMUL: begin
                if (tf_ff[scfp_pkg::IDX_CNT] == 8'h00) begin
                    nxt_cfg.multEn = 1'b0;
                end else if (tf_ff[scfp_pkg::IDX_CNT] <= MULT_MAX) begin
                    nxt_cfg.multEn = 1'b1;
                    nxt_cfg.multCnt = tf_ff[scfp_pkg::IDX_CNT];
                end else begin
                    nxt_cfg.multEn = 1'b0;
                    nxt_abort = 1'b1;
                end
            end
            scfp_pkg::CMD_SLP0, scfp_pkg::CMD_SLP1: nxt_sleep = 1'b1;
            scfp_pkg::CMD_STB0, scfp_pkg::CMD_STB1: nxt_sleep = 1'b1;
            default: nxt_abort = 1'b1;
        endcase
    end

    // soft reset request from the control register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            srst_ff <= 1'b0;
        end else begin
            srst_ff <= wrFire && wlane_ff && (wIdx == 6'(scfp_pkg::IDX_CTRL))
                && wdat_ff[scfp_pkg::CT_SRST];
        end
    end

    // feature settings; power-on and hardware reset load the defaults
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ff <= CFG_DEF;
        end else if (srst_ff) begin
            if (!cfg_ff.porKeep) begin
                cfg_ff <= CFG_DEF;
            end
        end else if (state_ff == scfp_pkg::ST_EXEC) begin
            cfg_ff <= nxt_cfg;
        end
    end

    // task-file bytes; host writes are ignored while busy
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 1; i <= 6; i++) begin
                tf_ff[i] <= 8'h00;
            end
            cmd_ff <= 8'h00;
        end else if (state_ff == scfp_pkg::ST_EXEC && nxt_wb) begin
            tf_ff[scfp_pkg::IDX_CYLLO] <= CUR_MIN;
            tf_ff[scfp_pkg::IDX_CYLHI] <= CUR_MAX;
        end else if (wrFire && wlane_ff && state_ff == scfp_pkg::ST_IDLE) begin
            if (wIdx >= 6'(scfp_pkg::IDX_FEAT) && wIdx <= 6'(scfp_pkg::IDX_DRVHD)) begin
                tf_ff[wIdx[2:0]] <= wdat_ff[7:0];
            end else if (wIdx == 6'(scfp_pkg::IDX_CMD)) begin
                cmd_ff <= wdat_ff[7:0];
            end
        end
    end

    // sequencer: take, execute, optional flush, complete
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= scfp_pkg::ST_IDLE;
            busy_flag <= 1'b0;
            cmdIrq <= 1'b0;
            flushReq <= 1'b0;
            errFlag_ff <= 1'b0;
            sleepPend_ff <= 1'b0;
        end else begin
            cmdIrq <= 1'b0;
            case (state_ff)
                scfp_pkg::ST_IDLE: begin
                    if (cmdTake) begin
                        busy_flag <= 1'b1;
                        errFlag_ff <= 1'b0;
                        state_ff <= scfp_pkg::ST_EXEC;
                    end
                end
                scfp_pkg::ST_EXEC: begin
                    errFlag_ff <= nxt_abort;
                    sleepPend_ff <= nxt_sleep;
                    if (nxt_flush) begin
                        flushReq <= 1'b1;
                        state_ff <= scfp_pkg::ST_FLUSH;
                    end else begin
                        state_ff <= scfp_pkg::ST_DONE;
                    end
                end
                scfp_pkg::ST_FLUSH: begin
                    if (flushDone) begin
                        flushReq <= 1'b0;
                        state_ff <= scfp_pkg::ST_DONE;
                    end
                end
                default: begin
                    busy_flag <= 1'b0;
                    cmdIrq <= 1'b1;
                    sleepPend_ff <= 1'b0;
                    state_ff <= scfp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // sleep state and idle timer; any new command wakes the card
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleepMode <= 1'b0;
            idle_ff <= 20'h00000;
        end else if (cmdTake || srst_ff) begin
            sleepMode <= 1'b0;
            idle_ff <= 20'h00000;
        end else if (state_ff == scfp_pkg::ST_DONE && sleepPend_ff) begin
            sleepMode <= 1'b1;
        end else if (state_ff == scfp_pkg::ST_IDLE && !sleepMode) begin
            if (idle_ff == IDLE_LAST) begin
                sleepMode <= 1'b1;
                idle_ff <= 20'h00000;
            end else begin
                idle_ff <= idle_ff + 20'h00001;
            end
        end
    end

    // registered mode outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flow_ready_signal <= 1'b1;
            standbyOk <= 1'b1;
            writeCacheEn <= 1'b0;
            pioMode <= 3'h0;
            dmaMode <= 3'h0;
        end else begin
            flow_ready_signal <= (cfg_ff.pio >= scfp_pkg::PIO_FLOW_MIN) || !cfg_ff.flowOff;
            standbyOk <= !cfg_ff.apmEn || (cfg_ff.apmLvl < scfp_pkg::APM_NOSTBY);
            writeCacheEn <= cfg_ff.wcache;
            pioMode <= cfg_ff.pio;
            dmaMode <= cfg_ff.dma;
        end
    end

    sequence takeSeq;
        cmdTake;
    endsequence
    sequence doneSeq;
        cmdIrq && !busy_flag;
    endsequence

    busy_on_take_a: assert property (@(posedge clk) disable iff (!rstn)
        takeSeq |=> busy_flag) else $error("busy not raised on command");
    done_noflush_a: assert property (@(posedge clk) disable iff (!rstn)
        takeSeq ##1 !nxt_flush |=> ##1 doneSeq) else $error("completion late");
    flush_before_irq_a: assert property (@(posedge clk) disable iff (!rstn)
        flushReq && !flushDone |=> !cmdIrq && busy_flag) else $error("irq before flush");
    flow_ready_a: assert property (@(posedge clk) disable iff (!rstn)
        pioMode >= 3'h3 |-> flow_ready_signal) else $error("flow ready off");
    standby_level_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 $past(cfg_ff.apmEn) && $past(cfg_ff.apmLvl) >= 8'h80 |-> !standbyOk)
        else $error("standby allowed at high level");
    abort_unknown_a: assert property (@(posedge clk) disable iff (!rstn)
        state_ff == scfp_pkg::ST_EXEC && cmd_ff == 8'hEF && tf_ff[1] == 8'h7F
        |=> errFlag_ff ##1 doneSeq) else $error("bad subcommand not aborted");
    mult_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        state_ff == scfp_pkg::ST_EXEC && cmd_ff == 8'hC6 && tf_ff[2] == 8'h00
        |=> !cfg_ff.multEn && !errFlag_ff) else $error("zero count mishandled");
    sleep_cmd_a: assert property (@(posedge clk) disable iff (!rstn)
        state_ff == scfp_pkg::ST_EXEC && cmd_ff == 8'hE2
        |=> ##1 sleepMode && !busy_flag) else $error("standby not entered");
    cur_writeback_a: assert property (@(posedge clk) disable iff (!rstn)
        state_ff == scfp_pkg::ST_EXEC && cmd_ff == 8'hEF && tf_ff[1] == 8'h9A
        |=> tf_ff[4] == CUR_MIN && tf_ff[5] == CUR_MAX) else $error("limits not written");
    cur_clamp_a: assert property (@(posedge clk) disable iff (!rstn)
        cfg_ff.curLim >= CUR_MIN && cfg_ff.curLim <= CUR_MAX) else $error("limit unclamped");
endmodule
`default_nettype wire

// *** scfp_flush_model.sv ***
// flush responder behind the write cache, answer lag set by the bench
`timescale 1ns/1ps
`default_nettype none
module scfp_flush_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] lag,
    input wire logic flushReq,
    output logic flushDone
);
    logic [3:0] waitCnt_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitCnt_ff <= 4'h0;
            flushDone <= 1'b0;
        end else begin
            flushDone <= flushReq && !flushDone && waitCnt_ff == lag;
            waitCnt_ff <= (flushReq && waitCnt_ff != lag) ? waitCnt_ff + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the feature and power command block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic busy_flag, cmdIrq, sleepMode, flushReq, flushDone, flow_ready_signal;
    logic standbyOk, writeCacheEn;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, lag = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [2:0] pioMode, dmaMode;
    logic [15:0] xm[8] = '{16'h0C04, 16'h2214, 16'h0B13, 16'h0010, 16'h0D90, 16'h1090,
        16'h2390, 16'h0150};
    logic [7:0] sl[4] = '{8'h99, 8'hE6, 8'h96, 8'hE2};
    logic [15:0] ft[9] = '{16'h4453, 16'hAA73, 16'h8A33, 16'h0A73, 16'h5553, 16'hBB43,
        16'h6943, 16'h9643, 16'h9743};
    int fail_count = 0, num_checks = 0, cycles = 0, flushes = 0;
    always #4 clk = ~clk;
    scfp_feature_power #(.IDLE_CYCLES(200)) scfp_feature_power_i (.*);
    scfp_flush_model scfp_flush_model_i (.*);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input int i, input logic [7:0] d);
        @(posedge clk);
        s_axi_awaddr <= 8'(4 * i);
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task rdc(input int i, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        s_axi_araddr <= 8'(4 * i);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rr = s_axi_rresp;
        chk($sformatf("reg%0d", i), s_axi_rdata & m, e);
        s_axi_rready <= 1'b0;
    endtask
    task cmd(input logic [7:0] f, input logic [7:0] c, input logic [7:0] k, input logic ab);
        wr(1, f);
        wr(2, c);
        wr(7, k);
        for (int n = 0; n < 300 && busy_flag !== 1'b0; n++) @(negedge clk);
        chk("irq", cmdIrq, 1);
        rdc(1, 4, {29'h0, ab, 2'h0});
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (flushDone === 1'b1) flushes++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rdc(9, 32'hFFFFFF, 32'h32FE43);
        rdc(8, 32'hFFFF, 32'h0);
        cmd(8'h02, 8'h00, 8'hEF, 0);
        chk("cache", writeCacheEn, 1);
        lag <= 4'h6;
        cmd(8'h82, 8'h00, 8'hEF, 0);
        chk("cache", writeCacheEn, 0);
        chk("flush", flushes, 1);
        foreach (xm[j]) begin
            cmd(8'h03, xm[j][15:8], 8'hEF, xm[j][7]);
            rdc(8, 32'h7F, {25'h0, xm[j][6:0]});
            rdc(9, 32'h1, {31'h0, !xm[j][6]});
            chk("pio", pioMode, xm[j][2:0]);
            chk("dma", dmaMode, xm[j][5:3]);
        end
        cmd(8'h05, 8'h80, 8'hEF, 0);
        chk("standby", standbyOk, 0);
        cmd(8'h05, 8'h00, 8'hEF, 1);
        chk("standby", standbyOk, 0);
        cmd(8'h05, 8'hFF, 8'hEF, 1);
        cmd(8'h05, 8'h7F, 8'hEF, 0);
        chk("standby", standbyOk, 1);
        cmd(8'h85, 8'h00, 8'hEF, 0);
        chk("standby", standbyOk, 1);
        cmd(8'h8A, 8'h00, 8'hEF, 0);
        rdc(9, 32'h40, 32'h0);
        cmd(8'h01, 8'h00, 8'hEF, 1);
        cmd(8'h7F, 8'h00, 8'hEF, 1);
        cmd(8'h00, 8'h00, 8'h7F, 1);
        cmd(8'h9A, 8'h02, 8'hEF, 0);
        rdc(4, 32'hFF, 32'h05);
        rdc(5, 32'hFF, 32'h32);
        rdc(9, 32'hFF0000, 32'h050000);
        cmd(8'h9A, 8'h06, 8'hEF, 0);
        rdc(9, 32'hFF0000, 32'h060000);
        cmd(8'h9A, 8'h40, 8'hEF, 0);
        rdc(9, 32'hFF0000, 32'h320000);
        cmd(8'h00, 8'h20, 8'hC6, 1);
        rdc(8, 32'h80, 32'h0);
        cmd(8'h00, 8'h08, 8'hC6, 0);
        rdc(8, 32'hFF80, 32'h0880);
        cmd(8'h66, 8'h00, 8'hEF, 0);
        wr(10, 8'h01);
        rdc(8, 32'hFF80, 32'h0880);
        cmd(8'hCC, 8'h00, 8'hEF, 0);
        wr(10, 8'h01);
        rdc(8, 32'hFFFF, 32'h0);
        rdc(9, 32'hFFFFFF, 32'h32FE43);
        foreach (ft[j]) begin
            cmd(ft[j][15:8], 8'h00, 8'hEF, 0);
            rdc(9, 32'hFF, {24'h0, ft[j][7:0]});
        end
        foreach (sl[j]) begin
            cmd(8'h00, 8'h00, sl[j], 0);
            chk("sleep", sleepMode, 1);
            rdc(7, 32'hC3, 32'h42);
            cmd(8'h00, 8'h00, 8'hC6, 0);
            chk("sleep", sleepMode, 0);
        end
        repeat (250) @(posedge clk);
        chk("sleep", sleepMode, 1);
        rdc(11, 32'hFFFFFFFF, 32'h0);
        chk("rresp", rr, scfp_pkg::RESP_SLVERR);
        give_verdict;
    end
endmodule
`default_nettype wire
